// ==== src/fccr_pkg.sv ====
// Purpose: Shared constants for the fault, limit and calibration command bank
// Assumes: Linear-11 words, fixed point values carry FIX_FRAC fraction bits
// Notes:   Command codes double as the register offsets
package fccr_pkg;

    // Command codes
    localparam logic [7:0]  CMD_READ_TEMP2   = 8'h8e;
    localparam logic [7:0]  CMD_INDUCT       = 8'hd6;
    localparam logic [7:0]  CMD_CAPMASK      = 8'hd7;
    localparam logic [7:0]  CMD_VLIMCFG      = 8'hd8;
    localparam logic [7:0]  CMD_XGAIN        = 8'hd9;
    localparam logic [7:0]  CMD_XBIAS        = 8'hda;

    // Values after reset
    localparam logic [15:0] INDUCT_RST       = 16'hb133;
    localparam logic [15:0] CAPMASK_RST      = 16'h0000;
    localparam logic [7:0]  VLIMCFG_RST      = 8'h00;
    localparam logic [15:0] XGAIN_RST        = 16'hba00;
    localparam logic [15:0] XBIAS_RST        = 16'h0000;
    localparam logic [15:0] TEMP2_RST        = 16'h0000;

    // Field layouts
    localparam logic [15:0] CAPMASK_USED     = 16'h3cff;
    localparam logic [7:0]  VLIMCFG_USED     = 8'h8f;
    localparam int          VLIM_LOWSIDE_BIT = 7;
    localparam int          VLIM_N_MSB       = 3;
    localparam int          VLIM_N_LSB       = 0;
    localparam int          VLIM_N_W         = 4;
    localparam int          CAP_VOUT_OV_BIT  = 0;
    localparam int          CAP_VOUT_UV_BIT  = 1;
    localparam int          LIN_EXP_MSB      = 15;
    localparam int          LIN_EXP_LSB      = 11;
    localparam int          LIN_MAN_MSB      = 10;

    // Fixed point working format
    localparam int          FIX_FRAC         = 8;
    localparam int          FIX_W            = 48;
    localparam int          NORM_STEPS       = 23;

    // Accepted ranges, in fixed point
    localparam logic signed [47:0] INDUCT_MIN = 48'sh0;
    localparam logic signed [47:0] INDUCT_MAX = 48'sh6400;
    localparam logic signed [47:0] XGAIN_MIN  = 48'sh19;
    localparam logic signed [47:0] XGAIN_MAX  = 48'sha00;
    localparam logic signed [47:0] XBIAS_MIN  = -48'sh6400;
    localparam logic signed [47:0] XBIAS_MAX  = 48'sh6400;

    // Cycles from temperature sample to result
    localparam int          TEMP_LATENCY     = 2;

endpackage

// ==== src/fccr_vout_filter.sv ====
// Purpose: Consecutive violation filter for one output page
// Assumes: Samples and clears come from logic on the same clock
// Notes:   Separate run counters for overvoltage and undervoltage
`timescale 1ns/1ps
module fccr_vout_filter #(
    parameter int NW = fccr_pkg::VLIM_N_W
) (
    input  wire logic          clock,
    input  wire logic          sys_rst,
    input  wire logic          sample_valid,
    input  wire logic          ov_viol,
    input  wire logic          uv_viol,
    input  wire logic [NW-1:0] limit_n,
    input  wire logic          fault_clear,
    output logic               ov_declare,
    output logic               uv_declare,
    output logic               ov_fault,
    output logic               uv_fault
);
    logic [NW:0] ov_cnt_r;
    logic [NW:0] ov_cnt_nxt;
    logic [NW:0] uv_cnt_r;
    logic [NW:0] uv_cnt_nxt;
    logic        ov_fault_r;
    logic        ov_fault_nxt;
    logic        uv_fault_r;
    logic        uv_fault_nxt;
    logic [NW:0] limit_ext;

    assign limit_ext  = {1'b0, limit_n};
    assign ov_declare = sample_valid && ov_viol && (ov_cnt_r == limit_ext);
    assign uv_declare = sample_valid && uv_viol && (uv_cnt_r == limit_ext);
    assign ov_fault   = ov_fault_r;
    assign uv_fault   = uv_fault_r;

    function automatic logic [NW:0] run_step(input logic [NW:0] cnt, input logic viol);
        if (!viol) begin
            return '0;
        end
        return (&cnt) ? cnt : cnt + 1'b1;
    endfunction

    always_comb begin
        ov_cnt_nxt   = ov_cnt_r;
        uv_cnt_nxt   = uv_cnt_r;
        if (sample_valid) begin
            ov_cnt_nxt = run_step(ov_cnt_r, ov_viol);
            uv_cnt_nxt = run_step(uv_cnt_r, uv_viol);
        end
        // Set wins over clear
        ov_fault_nxt = ov_declare || (ov_fault_r && !fault_clear);
        uv_fault_nxt = uv_declare || (uv_fault_r && !fault_clear);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ov_cnt_r   <= '0;
            uv_cnt_r   <= '0;
            ov_fault_r <= 1'b0;
            uv_fault_r <= 1'b0;
        end else begin
            ov_cnt_r   <= ov_cnt_nxt;
            uv_cnt_r   <= uv_cnt_nxt;
            ov_fault_r <= ov_fault_nxt;
            uv_fault_r <= uv_fault_nxt;
        end
    end

    sequence s_ov_hit;
        sample_valid && ov_viol;
    endsequence

    a_ov_run_length: assert property (@(posedge clock) disable iff (sys_rst)
        ov_declare |-> s_ov_hit and (ov_cnt_r == limit_ext))
        else $error("Overvoltage declared at wrong run length");

    a_run_restart: assert property (@(posedge clock) disable iff (sys_rst)
        (sample_valid && !ov_viol && !uv_viol) |=> (ov_cnt_r == '0) && (uv_cnt_r == '0))
        else $error("Run counter not cleared by in-limit sample");

    a_uv_fault_hold: assert property (@(posedge clock) disable iff (sys_rst)
        uv_declare |=> uv_fault ##0 (uv_fault || $past(fault_clear)))
        else $error("Undervoltage fault not latched");

endmodule

// ==== src/fccr_regs.sv ====
// Purpose: Paged fault, voltage limit and temperature calibration command bank
// Assumes: Command port and all event inputs come from logic on the same clock
// Notes:   Command answer one cycle after cmd_valid; temperature result two cycles after sample
`timescale 1ns/1ps
module fccr_regs #(
    parameter int PAGES = 2,
    parameter int PW    = (PAGES > 1) ? $clog2(PAGES) : 1
) (
    input  wire logic [7:0]          cmd_code,
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic                cmd_valid,
    input  wire logic                cmd_write,
    input  wire logic [PW-1:0]       cmd_page,
    input  wire logic [15:0]         cmd_wdata,
    output logic                     rsp_valid,
    output logic [15:0]              rsp_rdata,
    output logic                     rsp_error,
    input  wire logic                temp_valid,
    input  wire logic [PW-1:0]       temp_page,
    input  wire logic [15:0]         remote_sensor_input,
    output logic                     temp2_valid,
    output logic [15:0]              temp2_word,
    input  wire logic [PAGES-1:0]    vout_sample_valid,
    input  wire logic [PAGES-1:0]    vout_ov_viol,
    input  wire logic [PAGES-1:0]    vout_uv_viol,
    input  wire logic [PAGES-1:0]    fault_clear,
    input  wire logic [15:0]         fault_event,
    output logic                     snapshot_start,
    output logic [PAGES-1:0]         vout_ov_fault,
    output logic [PAGES-1:0]         vout_uv_fault,
    output logic [PAGES-1:0]         low_side_on,
    output logic [PAGES*16-1:0]      ripple_inductance
);
    typedef logic signed [fccr_pkg::FIX_W-1:0] fccr_fix_type;

    // Per page settings, shared capture mask and command answer
    logic [15:0]  induct_r  [PAGES];
    logic [15:0]  induct_nxt[PAGES];
    logic [15:0]  xgain_r   [PAGES];
    logic [15:0]  xgain_nxt [PAGES];
    logic [15:0]  xbias_r   [PAGES];
    logic [15:0]  xbias_nxt [PAGES];
    logic [7:0]   vlim_r    [PAGES];
    logic [7:0]   vlim_nxt  [PAGES];
    logic [15:0]  temp2_r   [PAGES];
    logic [15:0]  temp2_nxt [PAGES];
    logic [15:0]  capmask_r;
    logic [15:0]  capmask_nxt;
    logic         rsp_valid_r;
    logic         rsp_valid_nxt;
    logic [15:0]  rsp_rdata_r;
    logic [15:0]  rsp_rdata_nxt;
    logic         rsp_error_r;
    logic         rsp_error_nxt;

    // Temperature pipeline
    logic         s1_valid_r;
    logic         s1_valid_nxt;
    logic [PW-1:0] s1_page_r;
    logic [PW-1:0] s1_page_nxt;
    fccr_fix_type s1_num_r;
    fccr_fix_type s1_num_nxt;
    fccr_fix_type s1_den_r;
    fccr_fix_type s1_den_nxt;
    fccr_fix_type s1_bias_r;
    fccr_fix_type s1_bias_nxt;
    logic         t2_valid_r;
    logic         t2_valid_nxt;
    logic [15:0]  t2_word_r;
    logic [15:0]  t2_word_nxt;

    // Fault capture
    logic         snap_r;
    logic         snap_nxt;
    logic [PAGES-1:0] ov_declare;
    logic [PAGES-1:0] uv_declare;
    logic [15:0]  fault_all;

    // Linear word to fixed point
    function automatic fccr_fix_type lin_to_fix(input logic [15:0] w);
        logic signed [4:0] e;
        fccr_fix_type      m;
        int                sh;
        e  = w[fccr_pkg::LIN_EXP_MSB:fccr_pkg::LIN_EXP_LSB];
        m  = fccr_fix_type'(signed'(w[fccr_pkg::LIN_MAN_MSB:0]));
        sh = int'(e) + fccr_pkg::FIX_FRAC;
        if (sh >= 0) begin
            return m <<< sh;
        end
        return m >>> (-sh);
    endfunction

    // Fixed point to linear word, smallest exponent that fits
    function automatic logic [15:0] fix_to_lin(input fccr_fix_type v);
        fccr_fix_type      t;
        logic signed [5:0] e;
        t = v;
        e = -6'sh8;
        for (int i = 0; i < fccr_pkg::NORM_STEPS; i++) begin
            if (t > fccr_fix_type'(1023) || t < fccr_fix_type'(-1024)) begin
                t = t >>> 1;
                e = e + 6'sh1;
            end
        end
        return {e[4:0], t[fccr_pkg::LIN_MAN_MSB:0]};
    endfunction

    function automatic logic in_range(input logic [15:0] w, input fccr_fix_type lo, input fccr_fix_type hi);
        fccr_fix_type f;
        f = lin_to_fix(w);
        return (f >= lo) && (f <= hi);
    endfunction

    // Command decode and settings
    always_comb begin
        capmask_nxt   = capmask_r;
        rsp_valid_nxt = cmd_valid;
        rsp_rdata_nxt = 16'h0000;
        rsp_error_nxt = 1'b0;
        for (int p = 0; p < PAGES; p++) begin
            induct_nxt[p] = induct_r[p];
            xgain_nxt[p]  = xgain_r[p];
            xbias_nxt[p]  = xbias_r[p];
            vlim_nxt[p]   = vlim_r[p];
        end
        if (cmd_valid) begin
            if (int'(cmd_page) >= PAGES) begin
                rsp_error_nxt = 1'b1;
            end else if (cmd_write) begin
                unique case (cmd_code)
                    fccr_pkg::CMD_INDUCT: begin
                        if (in_range(cmd_wdata, fccr_pkg::INDUCT_MIN, fccr_pkg::INDUCT_MAX)) begin
                            induct_nxt[cmd_page] = cmd_wdata;
                        end else begin
                            rsp_error_nxt = 1'b1;
                        end
                    end
                    fccr_pkg::CMD_CAPMASK: capmask_nxt = cmd_wdata & fccr_pkg::CAPMASK_USED;
                    fccr_pkg::CMD_VLIMCFG: vlim_nxt[cmd_page] = cmd_wdata[7:0] & fccr_pkg::VLIMCFG_USED;
                    fccr_pkg::CMD_XGAIN: begin
                        if (in_range(cmd_wdata, fccr_pkg::XGAIN_MIN, fccr_pkg::XGAIN_MAX)) begin
                            xgain_nxt[cmd_page] = cmd_wdata;
                        end else begin
                            rsp_error_nxt = 1'b1;
                        end
                    end
                    fccr_pkg::CMD_XBIAS: begin
                        if (in_range(cmd_wdata, fccr_pkg::XBIAS_MIN, fccr_pkg::XBIAS_MAX)) begin
                            xbias_nxt[cmd_page] = cmd_wdata;
                        end else begin
                            rsp_error_nxt = 1'b1;
                        end
                    end
                    default: rsp_error_nxt = 1'b1;
                endcase
            end else begin
                unique case (cmd_code)
                    fccr_pkg::CMD_INDUCT:     rsp_rdata_nxt = induct_r[cmd_page];
                    fccr_pkg::CMD_CAPMASK:    rsp_rdata_nxt = capmask_r;
                    fccr_pkg::CMD_VLIMCFG:    rsp_rdata_nxt = {8'h00, vlim_r[cmd_page]};
                    fccr_pkg::CMD_XGAIN:      rsp_rdata_nxt = xgain_r[cmd_page];
                    fccr_pkg::CMD_XBIAS:      rsp_rdata_nxt = xbias_r[cmd_page];
                    fccr_pkg::CMD_READ_TEMP2: rsp_rdata_nxt = temp2_r[cmd_page];
                    default:                  rsp_error_nxt = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < PAGES; p++) begin
                induct_r[p] <= fccr_pkg::INDUCT_RST;
                xgain_r[p]  <= fccr_pkg::XGAIN_RST;
                xbias_r[p]  <= fccr_pkg::XBIAS_RST;
                vlim_r[p]   <= fccr_pkg::VLIMCFG_RST;
            end
            capmask_r   <= fccr_pkg::CAPMASK_RST;
            rsp_valid_r <= 1'b0;
            rsp_rdata_r <= 16'h0000;
            rsp_error_r <= 1'b0;
        end else begin
            for (int p = 0; p < PAGES; p++) begin
                induct_r[p] <= induct_nxt[p];
                xgain_r[p]  <= xgain_nxt[p];
                xbias_r[p]  <= xbias_nxt[p];
                vlim_r[p]   <= vlim_nxt[p];
            end
            capmask_r   <= capmask_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_rdata_r <= rsp_rdata_nxt;
            rsp_error_r <= rsp_error_nxt;
        end
    end

    // Temperature calibration
    always_comb begin
        fccr_fix_type q;
        q            = '0;
        s1_valid_nxt = temp_valid;
        s1_page_nxt  = temp_page;
        s1_num_nxt   = lin_to_fix(remote_sensor_input) <<< fccr_pkg::FIX_FRAC;
        s1_den_nxt   = lin_to_fix(xgain_r[temp_page]);
        s1_bias_nxt  = lin_to_fix(xbias_r[temp_page]);
        if (s1_den_r != '0) begin
            q = s1_num_r / s1_den_r;
        end
        t2_valid_nxt = s1_valid_r;
        t2_word_nxt  = s1_valid_r ? fix_to_lin(q + s1_bias_r) : t2_word_r;
        for (int p = 0; p < PAGES; p++) begin
            temp2_nxt[p] = (s1_valid_r && int'(s1_page_r) == p) ? t2_word_nxt : temp2_r[p];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s1_valid_r <= 1'b0;
            s1_page_r  <= '0;
            s1_num_r   <= '0;
            s1_den_r   <= '0;
            s1_bias_r  <= '0;
            t2_valid_r <= 1'b0;
            t2_word_r  <= fccr_pkg::TEMP2_RST;
            for (int p = 0; p < PAGES; p++) begin
                temp2_r[p] <= fccr_pkg::TEMP2_RST;
            end
        end else begin
            s1_valid_r <= s1_valid_nxt;
            s1_page_r  <= s1_page_nxt;
            s1_num_r   <= s1_num_nxt;
            s1_den_r   <= s1_den_nxt;
            s1_bias_r  <= s1_bias_nxt;
            t2_valid_r <= t2_valid_nxt;
            t2_word_r  <= t2_word_nxt;
            for (int p = 0; p < PAGES; p++) begin
                temp2_r[p] <= temp2_nxt[p];
            end
        end
    end

    // Output voltage fault filters
    for (genvar g = 0; g < PAGES; g++) begin : g_page
        fccr_vout_filter u_filter (
            .clock        (clock),
            .sys_rst      (sys_rst),
            .sample_valid (vout_sample_valid[g]),
            .ov_viol      (vout_ov_viol[g]),
            .uv_viol      (vout_uv_viol[g]),
            .limit_n      (vlim_r[g][fccr_pkg::VLIM_N_MSB:fccr_pkg::VLIM_N_LSB]),
            .fault_clear  (fault_clear[g]),
            .ov_declare   (ov_declare[g]),
            .uv_declare   (uv_declare[g]),
            .ov_fault     (vout_ov_fault[g]),
            .uv_fault     (vout_uv_fault[g])
        );
        assign low_side_on[g] = vout_ov_fault[g] && vlim_r[g][fccr_pkg::VLIM_LOWSIDE_BIT];
        assign ripple_inductance[g*16 +: 16] = induct_r[g];
    end

    // Snapshot trigger
    always_comb begin
        fault_all = fault_event;
        fault_all[fccr_pkg::CAP_VOUT_OV_BIT] = fault_event[fccr_pkg::CAP_VOUT_OV_BIT] || (|ov_declare);
        fault_all[fccr_pkg::CAP_VOUT_UV_BIT] = fault_event[fccr_pkg::CAP_VOUT_UV_BIT] || (|uv_declare);
        snap_nxt  = |(fault_all & ~capmask_r & fccr_pkg::CAPMASK_USED);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            snap_r <= 1'b0;
        end else begin
            snap_r <= snap_nxt;
        end
    end

    assign rsp_valid      = rsp_valid_r;
    assign rsp_rdata      = rsp_rdata_r;
    assign rsp_error      = rsp_error_r;
    assign temp2_valid    = t2_valid_r;
    assign temp2_word     = t2_word_r;
    assign snapshot_start = snap_r;

    // Checks
    logic induct_written_r;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            induct_written_r <= 1'b0;
        end else if (cmd_valid && cmd_write && cmd_code == fccr_pkg::CMD_INDUCT) begin
            induct_written_r <= 1'b1;
        end
    end

    sequence s_read(logic [7:0] code);
        cmd_valid && !cmd_write && cmd_code == code;
    endsequence
    a_induct_default: assert property (@(posedge clock) disable iff (sys_rst)
        s_read(fccr_pkg::CMD_INDUCT) and !induct_written_r |=> rsp_rdata == 16'hb133)
        else $error("Inductance default wrong");
    a_induct_refuse: assert property (@(posedge clock) disable iff (sys_rst)
        (cmd_valid && cmd_write && cmd_code == fccr_pkg::CMD_INDUCT && cmd_wdata[15] == 1'b0
         && cmd_wdata[10] == 1'b1) |=> rsp_error && $stable(ripple_inductance[15:0]))
        else $error("Negative inductance accepted");
    a_mask_blocks: assert property (@(posedge clock) disable iff (sys_rst)
        ((fault_all & ~capmask_r & 16'h3cff) == 16'h0000) |=> !snapshot_start)
        else $error("Masked fault started a snapshot");
    a_mask_unused: assert property (@(posedge clock) disable iff (sys_rst)
        s_read(fccr_pkg::CMD_CAPMASK) |=> rsp_rdata[15:14] == 2'b00 && rsp_rdata[9:8] == 2'b00)
        else $error("Unused mask bits read nonzero");
    a_ov_capture: assert property (@(posedge clock) disable iff (sys_rst)
        (|ov_declare) && !capmask_r[0] |=> snapshot_start)
        else $error("Output overvoltage did not start snapshot");
    a_low_side: assert property (@(posedge clock) disable iff (sys_rst)
        ov_declare[0] && !fault_clear[0] |=> low_side_on[0] == vlim_r[0][7])
        else $error("Low side state wrong after overvoltage");
    a_vlim_unused: assert property (@(posedge clock) disable iff (sys_rst)
        s_read(fccr_pkg::CMD_VLIMCFG) |=> rsp_rdata[15:8] == 8'h00 && rsp_rdata[6:4] == 3'b000)
        else $error("Unused limit config bits read nonzero");
    a_temp_latency: assert property (@(posedge clock) disable iff (sys_rst)
        temp_valid |-> ##2 temp2_valid)
        else $error("Temperature result late");
endmodule

// ==== bench/fccr_host.sv ====
// Purpose: Command host model driving the bank's command port
// Assumes: Answer arrives within four cycles of the strobe
// Notes:   Released code and data lines show inverted values
`timescale 1ns/1ps
module fccr_host (
    input  wire logic        clock,
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic [7:0]       cmd_code,
    output logic [0:0]       cmd_page,
    output logic [15:0]      cmd_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [15:0] rsp_rdata,
    input  wire logic        rsp_error
);
    initial {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = '0;
    task automatic xfer(input logic w, input logic [7:0] c, input logic p, input logic [15:0] d,
                        output logic [16:0] r);
        int i;
        @(posedge clock);
        #1;
        {cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata} = {1'b1, w, c, p, d};
        @(posedge clock);
        #1;
        {cmd_valid, cmd_code, cmd_wdata} = {1'b0, ~c, ~d};
        for (i = 0; i < 4 && rsp_valid !== 1'b1; i++) @(posedge clock) #1;
        r = (rsp_valid === 1'b1) ? {rsp_rdata, rsp_error} : 17'h1ffff;
    endtask
endmodule

// ==== bench/tb.sv ====
// Purpose: Self checking bench for the command bank
// Assumes: Two pages, commands through the host model
// Notes:   Temperature cases stay exactly representable
`timescale 1ns/1ps
module tb;
    logic        clock = 1'b0, sys_rst = 1'b1, temp_valid = 1'b0, temp_page = 1'b0;
    logic [15:0] remote_sensor_input = '0, fault_event = '0;
    logic [1:0]  vout_sample_valid = '0, vout_ov_viol = '0, vout_uv_viol = '0, fault_clear = '0;
    logic        cmd_valid, cmd_write, cmd_page, rsp_valid, rsp_error, temp2_valid, snapshot_start;
    logic [7:0]  cmd_code, c;
    logic [15:0] cmd_wdata, rsp_rdata, temp2_word, iw [2], tw [2];
    logic [1:0]  vout_ov_fault, vout_uv_fault, low_side_on;
    logic [31:0] ripple_inductance, ri;
    int          errors = 0, n_checks = 0, snaps = 0, seed = 32'h20d27cda, p, k, n, t, b, s0;
    fccr_regs #(.PAGES(2)) uut (.cmd_code, .clock, .sys_rst, .cmd_valid, .cmd_write, .cmd_page,
        .cmd_wdata, .rsp_valid, .rsp_rdata, .rsp_error, .temp_valid, .temp_page, .remote_sensor_input,
        .temp2_valid, .temp2_word, .vout_sample_valid, .vout_ov_viol, .vout_uv_viol, .fault_clear,
        .fault_event, .snapshot_start, .vout_ov_fault, .vout_uv_fault, .low_side_on, .ripple_inductance);
    fccr_host host (.clock, .cmd_valid, .cmd_write, .cmd_code, .cmd_page, .cmd_wdata, .rsp_valid,
        .rsp_rdata, .rsp_error);
    always #2.5 clock = ~clock;
    always @(posedge clock) if (snapshot_start === 1'b1) snaps++;
    task automatic step(input int m);
        repeat (m) @(posedge clock);
        #1;
    endtask
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic io(input logic w, input logic [7:0] cd, input logic pg, input logic [15:0] d,
                      input logic [15:0] xq, input logic xe);
        logic [16:0] r;
        host.xfer(w, cd, pg, d, r);
        check($sformatf("cmd %h", cd), r, {xq, xe});
    endtask
    task automatic samp(input int pg, input int kd, input logic v);
        {vout_sample_valid[pg], vout_ov_viol[pg], vout_uv_viol[pg]} = {1'b1, v & (kd == 0), v & (kd == 1)};
        step(1);
        {vout_sample_valid, vout_ov_viol, vout_uv_viol} = {2'b00, ~vout_ov_viol, ~vout_uv_viol};
        step(1);
    endtask
    function automatic logic [15:0] enc(input int v);
        int e = -8;
        while (v > 1023 || v < -1024) begin
            v = v >>> 1;
            e++;
        end
        return {e[4:0], v[10:0]};
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        step(20);
        sys_rst = 1'b0;
        check("ripple", ripple_inductance, 32'hb133b133);
        for (k = 0; k < 10; k++) io(0, 8'hd6 + k % 5, k / 5, 0, (k % 5 == 0) ? 16'hb133 :
            (k % 5 == 3) ? 16'hba00 : 16'h0000, 0);
        $display("reset test done");
        io(1, 8'hd6, 0, 16'h0065, 0, 1);
        io(1, 8'hd9, 0, 16'h000b, 0, 1);
        io(1, 8'hda, 0, 16'h079b, 0, 1);
        io(1, 8'hd6, 1, 16'h0400, 0, 1);
        io(1, 8'hd9, 1, 16'h0000, 0, 1);
        io(1, 8'h8e, 0, 16'h0001, 0, 1);
        io(0, 8'hd6, 0, 0, 16'hb133, 0);
        $display("range test done");
        for (p = 0; p < 2; p++) begin
            n = $unsigned($random(seed)) % 101;
            iw[p] = {5'd0, n[10:0]};
            ri[16*p+:16] = iw[p];
            c = 8'($random(seed));
            io(1, 8'hd6, p[0], iw[p], 0, 0);
            io(1, 8'hd8, p[0], {8'h00, c}, 0, 0);
            io(0, 8'hd8, p[0], 0, {8'h00, c & 8'h8f}, 0);
            k = $unsigned($random(seed)) % 2;
            b = $unsigned($random(seed)) % 41 - 20;
            t = $unsigned($random(seed)) % 101 - 50;
            io(1, 8'hd9, p[0], k ? 16'h0002 : 16'hba00, 0, 0);
            io(1, 8'hda, p[0], {5'd0, b[10:0]}, 0, 0);
            tw[p] = enc(t * 256 / (k + 1) + b * 256);
            {temp_valid, temp_page, remote_sensor_input} = {1'b1, p[0], 5'd0, t[10:0]};
            step(1);
            {temp_valid, remote_sensor_input} = {1'b0, ~remote_sensor_input};
            for (n = 0; n < 4 && temp2_valid !== 1'b1; n++) step(1);
            check("temp2 valid", temp2_valid, 1'b1);
            check("temp2", temp2_word, tw[p]);
        end
        check("ripple", ripple_inductance, ri);
        for (p = 0; p < 2; p++) io(0, 8'hd6, p[0], 0, iw[p], 0);
        for (p = 0; p < 2; p++) io(0, 8'h8e, p[0], 0, tw[p], 0);
        $display("register test done");
        io(1, 8'hd7, 0, 0, 0, 0);
        for (p = 0; p < 2; p++) for (k = 0; k < 2; k++) begin
            n = $unsigned($random(seed)) % 16;
            c = 8'($random(seed));
            c = (c & 8'h80) | n[7:0];
            io(1, 8'hd8, p[0], {8'h00, c}, 0, 0);
            s0 = snaps;
            repeat (n) samp(p, k, 1);
            samp(p, k, 0);
            repeat (n) samp(p, k, 1);
            check("early", {vout_ov_fault[p], vout_uv_fault[p]}, 0);
            samp(p, k, 1);
            check("fault", {vout_ov_fault[p], vout_uv_fault[p]}, {k == 0, k == 1});
            check("low side", low_side_on[p], c[7] & (k == 0));
            check("snap", snaps - s0, 1);
            fault_clear[p] = 1'b1;
            step(1);
            fault_clear = 2'b00;
        end
        $display("filter test done");
        for (k = 0; k < 16; k++) if (16'h3cff & (16'h1 << k)) begin
            for (n = 0; n < 2; n++) begin
                io(1, 8'hd7, 0, n ? ~(16'h1 << k) : 16'h1 << k, 0, 0);
                s0 = snaps;
                fault_event[k] = 1'b1;
                step(1);
                fault_event = 16'h0000;
                step(2);
                check("mask", snaps - s0, n);
            end
        end
        $display("mask test done");
        finish_test();
    end
endmodule
